//--- echo_cancel_params.svh
`ifndef ECHO_CANCEL_PARAMS_SVH
`define ECHO_CANCEL_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_ECHO_CANCEL_CONTROL 4'h0
`define OFS_LOWBAND_SECTION_SETTING 4'h1
`define OFS_MIDBAND_SECTION_SETTING 4'h2
`define OFS_CANCEL_STATUS 4'h3

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define BIT_CANCEL_ENABLE 7
`define BIT_CANCEL_PHASE 6
`define BIT_MIDBAND_INSERT 5
`define ATTEN_CODE_MAX 5'h18
`define CONTROL_RESET 8'h00
`define LOWBAND_RESET 8'h00
`define MIDBAND_RESET 8'h00
`define LOWBAND_BYPASS_CODE 8'h00
`define BIT_LOWBAND_FIRST_ORDER 7

`endif

//--- echo_cancel_pkg.sv
package echo_cancel_pkg;

	typedef enum logic [1:0] {
		LOWBAND_BYPASS,
		LOWBAND_BIQUAD,
		LOWBAND_FIRST_ORDER
	} lowband_mode_t;

	typedef struct packed {
		logic enable;
		logic no_inversion;
		logic midband_insert;
		logic [4:0] atten_code;
		lowband_mode_t lowband_mode;
		logic [6:0] lowband_pole_zero;
		logic [3:0] midband_pole;
		logic [3:0] midband_zero;
	} cancel_cfg_t;

endpackage

//--- atten_clamp.sv
`timescale 1ns/1ps
`include "echo_cancel_params.svh"

module atten_clamp (
	// Raw code
	input wire logic [4:0] i_code,
	// Clamped code
	output logic [4:0] o_code,
	output logic o_reserved
);

	always_comb begin
		o_reserved = (i_code > `ATTEN_CODE_MAX);
		o_code = o_reserved ? `ATTEN_CODE_MAX : i_code;
	end

endmodule

//--- echo_cancel_filter_config.sv
// Contract
// - Bit 7 clear disables cancellation entirely
// - Bit 6 selects cancellation phase
// - Bit 5 inserts or bypasses midband section
// - Low five bits set attenuation code
// - Second register bypasses/selects lowband form
// - First-order lowband has programmable pole/zero
// - Third register holds midband pole, zero
// - Filter disabled after power-up
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "echo_cancel_params.svh"

module echo_cancel_filter_config
	import echo_cancel_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Filter configuration
	output cancel_cfg_t o_cfg
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] control_reg, control_next;
	logic [7:0] lowband_reg, lowband_next;
	logic [7:0] midband_reg, midband_next;
	logic [2:0] written_reg, written_next;
	logic [7:0] rdata_reg, rdata_next;
	cancel_cfg_t cfg_reg, cfg_next;
	logic [4:0] atten_clamped;
	logic atten_reserved;

	atten_clamp u_clamp (
		.i_code(control_reg[4:0]),
		.o_code(atten_clamped),
		.o_reserved(atten_reserved)
	);

	always_comb begin
		control_next = control_reg;
		lowband_next = lowband_reg;
		midband_next = midband_reg;
		written_next = written_reg;
		if (i_wr) begin
			unique case (i_addr)
				`OFS_ECHO_CANCEL_CONTROL: begin
					control_next = i_wdata;
					written_next[0] = 1'b1;
				end
				`OFS_LOWBAND_SECTION_SETTING: begin
					lowband_next = i_wdata;
					written_next[1] = 1'b1;
				end
				`OFS_MIDBAND_SECTION_SETTING: begin
					midband_next = i_wdata;
					written_next[2] = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`OFS_ECHO_CANCEL_CONTROL: rdata_next = control_reg;
				`OFS_LOWBAND_SECTION_SETTING: rdata_next = lowband_reg;
				`OFS_MIDBAND_SECTION_SETTING: rdata_next = midband_reg;
				`OFS_CANCEL_STATUS: begin
					rdata_next = {4'h0, atten_reserved, written_reg};
				end
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Decoded configuration
	// ----------------------------------------------------------------
	always_comb begin
		cfg_next.enable = control_reg[`BIT_CANCEL_ENABLE];
		cfg_next.no_inversion = control_reg[`BIT_CANCEL_PHASE];
		cfg_next.midband_insert = control_reg[`BIT_MIDBAND_INSERT];
		cfg_next.atten_code = atten_clamped;
		if (lowband_reg == `LOWBAND_BYPASS_CODE) begin
			cfg_next.lowband_mode = LOWBAND_BYPASS;
		end else if (lowband_reg[`BIT_LOWBAND_FIRST_ORDER]) begin
			cfg_next.lowband_mode = LOWBAND_FIRST_ORDER;
		end else begin
			cfg_next.lowband_mode = LOWBAND_BIQUAD;
		end
		cfg_next.lowband_pole_zero = lowband_reg[6:0];
		cfg_next.midband_pole = midband_reg[7:4];
		cfg_next.midband_zero = midband_reg[3:0];
		if (!control_reg[`BIT_CANCEL_ENABLE]) begin
			// Disabled path drops midband and bypasses lowband; phase and atten still pass
			cfg_next.midband_insert = 1'b0;
			cfg_next.lowband_mode = LOWBAND_BYPASS;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			control_reg <= `CONTROL_RESET;
			lowband_reg <= `LOWBAND_RESET;
			midband_reg <= `MIDBAND_RESET;
			written_reg <= 3'h0;
			rdata_reg <= 8'h00;
			cfg_reg <= '0;
		end else begin
			control_reg <= control_next;
			lowband_reg <= lowband_next;
			midband_reg <= midband_next;
			written_reg <= written_next;
			rdata_reg <= rdata_next;
			cfg_reg <= cfg_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_cfg = cfg_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_DISABLE: assert property (@(posedge i_mclk) disable iff (i_rst)
		!control_reg[`BIT_CANCEL_ENABLE] |=> !o_cfg.enable && !o_cfg.midband_insert
			&& o_cfg.lowband_mode == LOWBAND_BYPASS)
		else $error("cancellation not fully disabled");
	AST_PHASE: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_ECHO_CANCEL_CONTROL ##1 !i_wr [*1] |=>
			o_cfg.no_inversion == $past(i_wdata[`BIT_CANCEL_PHASE], 2))
		else $error("phase bit not applied");
	AST_MIDBAND_INSERT: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_cfg.midband_insert |-> $past(control_reg[`BIT_CANCEL_ENABLE])
			&& $past(control_reg[`BIT_MIDBAND_INSERT]))
		else $error("midband inserted without enable");
	AST_ATTEN: assert property (@(posedge i_mclk) disable iff (i_rst)
		control_reg[4:0] <= `ATTEN_CODE_MAX |=> o_cfg.atten_code == $past(control_reg[4:0]))
		else $error("attenuation code mismatch");
	AST_LOW_BYPASS: assert property (@(posedge i_mclk) disable iff (i_rst)
		lowband_reg == `LOWBAND_BYPASS_CODE |=> o_cfg.lowband_mode == LOWBAND_BYPASS)
		else $error("lowband not bypassed");
	AST_LOW_FIRST: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_cfg.lowband_mode == LOWBAND_FIRST_ORDER |->
			o_cfg.lowband_pole_zero == $past(lowband_reg[6:0]))
		else $error("first-order setting lost");
	AST_MIDBAND_PZ: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_MIDBAND_SECTION_SETTING |-> ##2
			{o_cfg.midband_pole, o_cfg.midband_zero} == $past(i_wdata, 2))
		else $error("midband pole/zero not stored");
	AST_RESET_OFF: assert property (@(posedge i_mclk)
		$past(i_rst) && !i_rst |-> !o_cfg.enable)
		else $error("filter enabled after reset");
	AST_CLAMP: assert property (@(posedge i_mclk) disable iff (i_rst)
		control_reg[4:0] > `ATTEN_CODE_MAX |=> o_cfg.atten_code == `ATTEN_CODE_MAX)
		else $error("reserved code not clamped");

	// ----------------------------------------------------------------
	// Register port checks
	// ----------------------------------------------------------------
	AST_WR_CTRL: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_ECHO_CANCEL_CONTROL
		|=> control_reg == $past(i_wdata))
		else $error("control write lost");
	AST_WR_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_LOWBAND_SECTION_SETTING
		|=> lowband_reg == $past(i_wdata))
		else $error("lowband write lost");
	AST_WR_MID: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_MIDBAND_SECTION_SETTING
		|=> midband_reg == $past(i_wdata))
		else $error("midband write lost");
	AST_CTRL_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
		!(i_wr && i_addr == `OFS_ECHO_CANCEL_CONTROL)
		|=> $stable(control_reg))
		else $error("control changed without write");
	AST_LOW_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
		!(i_wr && i_addr == `OFS_LOWBAND_SECTION_SETTING)
		|=> $stable(lowband_reg))
		else $error("lowband changed without write");
	AST_MID_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
		!(i_wr && i_addr == `OFS_MIDBAND_SECTION_SETTING)
		|=> $stable(midband_reg))
		else $error("midband changed without write");
	AST_WR_UNMAPPED: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr > `OFS_CANCEL_STATUS
		|=> $stable(control_reg) && $stable(lowband_reg) && $stable(midband_reg))
		else $error("unmapped write changed a register");
	AST_WRITTEN_CTRL: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_ECHO_CANCEL_CONTROL
		|=> written_reg[0])
		else $error("control written flag not set");
	AST_WRITTEN_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_LOWBAND_SECTION_SETTING
		|=> written_reg[1])
		else $error("lowband written flag not set");
	AST_WRITTEN_MID: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == `OFS_MIDBAND_SECTION_SETTING
		|=> written_reg[2])
		else $error("midband written flag not set");
	AST_WRITTEN_STICKY: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|=> (written_reg & $past(written_reg)) == $past(written_reg))
		else $error("written flag dropped");
	AST_RD_CTRL: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && i_addr == `OFS_ECHO_CANCEL_CONTROL
		|=> o_rdata == $past(control_reg))
		else $error("control readback wrong");
	AST_RD_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && i_addr == `OFS_LOWBAND_SECTION_SETTING
		|=> o_rdata == $past(lowband_reg))
		else $error("lowband readback wrong");
	AST_RD_MID: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && i_addr == `OFS_MIDBAND_SECTION_SETTING
		|=> o_rdata == $past(midband_reg))
		else $error("midband readback wrong");
	AST_RD_STATUS: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && i_addr == `OFS_CANCEL_STATUS
		|=> o_rdata == {4'h0, $past(atten_reserved), $past(written_reg)})
		else $error("status readback wrong");
	AST_RD_STATUS_TOP: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && i_addr == `OFS_CANCEL_STATUS
		|=> o_rdata[7:4] == 4'h0)
		else $error("status upper bits set");
	AST_RD_UNMAPPED: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && i_addr > `OFS_CANCEL_STATUS
		|=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_IDLE: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_rd
		|=> o_rdata == 8'h00)
		else $error("read data outside read cycle");

	// ----------------------------------------------------------------
	// Decode checks
	// ----------------------------------------------------------------
	AST_ENABLE_MAP: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|=> o_cfg.enable == $past(control_reg[`BIT_CANCEL_ENABLE]))
		else $error("enable not decoded");
	AST_PHASE_MAP: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|=> o_cfg.no_inversion == $past(control_reg[`BIT_CANCEL_PHASE]))
		else $error("phase not decoded");
	AST_MIDBAND_MAP: assert property (@(posedge i_mclk) disable iff (i_rst)
		control_reg[`BIT_CANCEL_ENABLE]
		|=> o_cfg.midband_insert == $past(control_reg[`BIT_MIDBAND_INSERT]))
		else $error("midband insert not decoded");
	AST_RESERVED_FLAG: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|-> atten_reserved == (control_reg[4:0] > `ATTEN_CODE_MAX))
		else $error("reserved flag wrong");
	AST_ATTEN_RANGE: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|-> o_cfg.atten_code <= `ATTEN_CODE_MAX)
		else $error("attenuation code out of range");
	AST_LOW_FIRST_MAP: assert property (@(posedge i_mclk) disable iff (i_rst)
		control_reg[`BIT_CANCEL_ENABLE] && lowband_reg[`BIT_LOWBAND_FIRST_ORDER]
		|=> o_cfg.lowband_mode == LOWBAND_FIRST_ORDER)
		else $error("first-order form not selected");
	AST_LOW_BIQUAD_MAP: assert property (@(posedge i_mclk) disable iff (i_rst)
		control_reg[`BIT_CANCEL_ENABLE] && lowband_reg != `LOWBAND_BYPASS_CODE
			&& !lowband_reg[`BIT_LOWBAND_FIRST_ORDER]
		|=> o_cfg.lowband_mode == LOWBAND_BIQUAD)
		else $error("second-order form not selected");
	AST_LOW_PZ_MAP: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|=> o_cfg.lowband_pole_zero == $past(lowband_reg[6:0]))
		else $error("lowband setting not decoded");
	AST_MODE_LEGAL: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|-> o_cfg.lowband_mode inside {LOWBAND_BYPASS, LOWBAND_BIQUAD, LOWBAND_FIRST_ORDER})
		else $error("illegal lowband mode");
	AST_MID_PZ_MAP: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1
		|=> {o_cfg.midband_pole, o_cfg.midband_zero} == $past(midband_reg))
		else $error("midband setting not decoded");
	AST_CFG_STABLE: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_wr ##1 1'b1
		|=> $stable(o_cfg))
		else $error("configuration changed without write");

	// ----------------------------------------------------------------
	// Reset checks
	// ----------------------------------------------------------------
	AST_RESET_CLEAR: assert property (@(posedge i_mclk)
		i_rst
		|=> o_cfg == '0 && o_rdata == 8'h00)
		else $error("outputs not cleared by reset");
	AST_RESET_WRITTEN: assert property (@(posedge i_mclk)
		i_rst
		|=> written_reg == 3'h0 && control_reg == `CONTROL_RESET)
		else $error("state not cleared by reset");

endmodule

//--- echo_cancel_filter_config_tb.sv
`timescale 1ns/1ps
`include "echo_cancel_params.svh"

module echo_cancel_filter_config_tb;
	import echo_cancel_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	cancel_cfg_t o_cfg;
	int miscompares = 0;
	int n_checks = 0;

	always #25 i_mclk = ~i_mclk;

	echo_cancel_filter_config u_echo_cancel_filter_config (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cfg(o_cfg));

	// ----------------------------------------------------------------
	// Bus cycles and compare
	// ----------------------------------------------------------------
	task chk(input string what, input logic [25:0] exp, input logic [25:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Write, then wait for the decoded outputs to settle
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		repeat (2) @(posedge i_mclk);
		#1;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge i_mclk);
		i_rd <= 1'b1; i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(what, {18'h0, exp}, {18'h0, o_rdata});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		chk("cfg at reset", 26'h0, 26'(o_cfg));
		rd(`OFS_ECHO_CANCEL_CONTROL, 8'h00, "control at reset");
		rd(`OFS_CANCEL_STATUS, 8'h00, "status at reset");
	endtask
	task t_control;
		wr(`OFS_ECHO_CANCEL_CONTROL, 8'hc5);
		chk("enable", 26'h1, o_cfg.enable);
		chk("phase", 26'h1, o_cfg.no_inversion);
		chk("midband insert", 26'h0, o_cfg.midband_insert);
		chk("atten", 26'h05, o_cfg.atten_code);
		rd(`OFS_ECHO_CANCEL_CONTROL, 8'hc5, "control readback");
		wr(`OFS_ECHO_CANCEL_CONTROL, 8'he0);
		chk("midband insert", 26'h1, o_cfg.midband_insert);
		chk("atten min", 26'h00, o_cfg.atten_code);
		wr(`OFS_ECHO_CANCEL_CONTROL, 8'h98);
		chk("phase", 26'h0, o_cfg.no_inversion);
		chk("atten max", 26'h18, o_cfg.atten_code);
	endtask
	task t_disable;
		wr(`OFS_LOWBAND_SECTION_SETTING, 8'h85);
		wr(`OFS_ECHO_CANCEL_CONTROL, 8'h3f);
		chk("enable off", 26'h0, o_cfg.enable);
		chk("midband off", 26'h0, o_cfg.midband_insert);
		chk("lowband off", 26'(LOWBAND_BYPASS), 26'(o_cfg.lowband_mode));
	endtask
	task t_reserved;
		wr(`OFS_ECHO_CANCEL_CONTROL, 8'hff);
		chk("atten clamp", 26'h18, o_cfg.atten_code);
		rd(`OFS_ECHO_CANCEL_CONTROL, 8'hff, "raw control");
		rd(`OFS_CANCEL_STATUS, 8'h0b, "status reserved");
	endtask
	task t_lowband;
		wr(`OFS_ECHO_CANCEL_CONTROL, 8'h80);
		chk("lowband first", 26'(LOWBAND_FIRST_ORDER), 26'(o_cfg.lowband_mode));
		chk("lowband setting", 26'h05, o_cfg.lowband_pole_zero);
		wr(`OFS_LOWBAND_SECTION_SETTING, 8'h05);
		chk("lowband biquad", 26'(LOWBAND_BIQUAD), 26'(o_cfg.lowband_mode));
		wr(`OFS_LOWBAND_SECTION_SETTING, 8'h00);
		chk("lowband bypass", 26'(LOWBAND_BYPASS), 26'(o_cfg.lowband_mode));
	endtask
	task t_midband;
		wr(`OFS_MIDBAND_SECTION_SETTING, 8'h3c);
		chk("midband pole", 26'h3, o_cfg.midband_pole);
		chk("midband zero", 26'hc, o_cfg.midband_zero);
		rd(`OFS_MIDBAND_SECTION_SETTING, 8'h3c, "midband readback");
		rd(`OFS_CANCEL_STATUS, 8'h07, "status all written");
	endtask
	task t_unmapped;
		wr(4'hf, 8'h5a);
		rd(4'hf, 8'h00, "unmapped read");
		rd(`OFS_ECHO_CANCEL_CONTROL, 8'h80, "control kept");
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge i_mclk);
		miscompares++;
		end_sim;
	end

	initial begin
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		#1;
		t_reset;
		t_control;
		t_disable;
		t_reserved;
		t_lowband;
		t_midband;
		t_unmapped;
		end_sim;
	end
endmodule
